// *** rtl/io_bank_pkg.sv ***
package io_bank_pkg;

    localparam int ADDR_W    = 6;
    localparam int DATA_W    = 8;
    localparam int BIT_W     = 3;
    localparam int NUM_REGS  = 64;

    localparam logic [DATA_W-1:0] REG_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] ALL_BITS   = 8'hff;
    localparam logic [DATA_W-1:0] NO_BITS    = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BIT    = 8'h01;
    // last address reachable by single-bit operations
    localparam logic [ADDR_W-1:0] BIT_OP_TOP = 6'h1f;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] STATUS_FLAGS          = 6'h3f;
    localparam logic [ADDR_W-1:0] STACK_POINTER_HIGH    = 6'h3e;
    localparam logic [ADDR_W-1:0] STACK_POINTER_LOW     = 6'h3d;
    localparam logic [ADDR_W-1:0] EXTERNAL_IRQ_MASK     = 6'h3b;
    localparam logic [ADDR_W-1:0] EXTERNAL_IRQ_FLAGS    = 6'h3a;
    localparam logic [ADDR_W-1:0] TIMER_IRQ_MASK        = 6'h39;
    localparam logic [ADDR_W-1:0] TIMER_IRQ_FLAGS       = 6'h38;
    localparam logic [ADDR_W-1:0] SELF_PROGRAM_CONTROL  = 6'h37;
    localparam logic [ADDR_W-1:0] CORE_CONTROL          = 6'h35;
    localparam logic [ADDR_W-1:0] RESET_CAUSE           = 6'h34;
    localparam logic [ADDR_W-1:0] TIMER0_CONTROL_B      = 6'h33;
    localparam logic [ADDR_W-1:0] TIMER0_COUNT          = 6'h32;
    localparam logic [ADDR_W-1:0] OSCILLATOR_TRIM       = 6'h31;
    localparam logic [ADDR_W-1:0] TIMER1_CONTROL        = 6'h30;
    localparam logic [ADDR_W-1:0] TIMER1_COUNT          = 6'h2f;
    localparam logic [ADDR_W-1:0] TIMER1_COMPARE_A      = 6'h2e;
    localparam logic [ADDR_W-1:0] TIMER1_COMPARE_C      = 6'h2d;
    localparam logic [ADDR_W-1:0] SHARED_TIMER_CONTROL  = 6'h2c;
    localparam logic [ADDR_W-1:0] TIMER1_COMPARE_B      = 6'h2b;
    localparam logic [ADDR_W-1:0] TIMER0_CONTROL_A      = 6'h2a;
    localparam logic [ADDR_W-1:0] TIMER0_COMPARE_A      = 6'h29;
    localparam logic [ADDR_W-1:0] TIMER0_COMPARE_B      = 6'h28;
    localparam logic [ADDR_W-1:0] FAST_CLOCK_CONTROL    = 6'h27;
    localparam logic [ADDR_W-1:0] CLOCK_DIVIDER         = 6'h26;
    localparam logic [ADDR_W-1:0] DEAD_TIME_A           = 6'h25;
    localparam logic [ADDR_W-1:0] DEAD_TIME_B           = 6'h24;
    localparam logic [ADDR_W-1:0] DEAD_TIME_PRESCALE    = 6'h23;
    localparam logic [ADDR_W-1:0] DEBUG_DATA            = 6'h22;
    localparam logic [ADDR_W-1:0] WATCHDOG_CONTROL      = 6'h21;
    localparam logic [ADDR_W-1:0] POWER_REDUCTION       = 6'h20;
    localparam logic [ADDR_W-1:0] NVDATA_ADDRESS_HIGH   = 6'h1f;
    localparam logic [ADDR_W-1:0] NVDATA_ADDRESS_LOW    = 6'h1e;
    localparam logic [ADDR_W-1:0] NVDATA_VALUE          = 6'h1d;
    localparam logic [ADDR_W-1:0] NVDATA_CONTROL        = 6'h1c;
    localparam logic [ADDR_W-1:0] PIN_OUTPUT_VALUE      = 6'h18;
    localparam logic [ADDR_W-1:0] PIN_DIRECTION         = 6'h17;
    localparam logic [ADDR_W-1:0] PIN_INPUT_VALUE       = 6'h16;
    localparam logic [ADDR_W-1:0] PIN_CHANGE_MASK       = 6'h15;
    localparam logic [ADDR_W-1:0] DIGITAL_INPUT_DISABLE = 6'h14;
    localparam logic [ADDR_W-1:0] SCRATCH_REG_2         = 6'h13;
    localparam logic [ADDR_W-1:0] SCRATCH_REG_1         = 6'h12;
    localparam logic [ADDR_W-1:0] SCRATCH_REG_0         = 6'h11;
    localparam logic [ADDR_W-1:0] SERIAL_IF_BUFFER      = 6'h10;
    localparam logic [ADDR_W-1:0] SERIAL_IF_SHIFT       = 6'h0f;
    localparam logic [ADDR_W-1:0] SERIAL_IF_STATUS      = 6'h0e;
    localparam logic [ADDR_W-1:0] SERIAL_IF_CONTROL     = 6'h0d;

    // ------------------------------------------------------------
    // command and carrier types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_IDLE       = 3'h0,
        OP_READ       = 3'h1,
        OP_WRITE      = 3'h2,
        OP_SET_BIT    = 3'h3,
        OP_CLEAR_BIT  = 3'h4,
        OP_SKIP_SET   = 3'h5,
        OP_SKIP_CLEAR = 3'h6
    } io_op_t;

    typedef struct packed {
        io_op_t              op;
        logic [ADDR_W-1:0]   addr;
        logic [BIT_W-1:0]    bit_sel;
        logic [DATA_W-1:0]   wdata;
    } io_cmd_t;

    typedef logic [NUM_REGS-1:0][DATA_W-1:0] reg_array_t;

    // per-address bit classes
    typedef struct packed {
        logic [DATA_W-1:0] rw;    // software read/write
        logic [DATA_W-1:0] w1c;   // hardware set, write one clears
        logic [DATA_W-1:0] hset;  // hardware set, software writable
        logic [DATA_W-1:0] live;  // follows hardware status, read only
    } bit_class_t;

    function automatic bit_class_t class_of(input logic [ADDR_W-1:0] a);
        bit_class_t c;
        c = '{rw: NO_BITS, w1c: NO_BITS, hset: NO_BITS, live: NO_BITS};
        unique case (a)
            STATUS_FLAGS, STACK_POINTER_LOW, CORE_CONTROL, TIMER0_COUNT,
            OSCILLATOR_TRIM, TIMER1_CONTROL, TIMER1_COUNT,
            TIMER1_COMPARE_A, TIMER1_COMPARE_C, SHARED_TIMER_CONTROL,
            TIMER1_COMPARE_B, TIMER0_COMPARE_A, TIMER0_COMPARE_B,
            DEAD_TIME_A, DEAD_TIME_B, DEBUG_DATA, NVDATA_ADDRESS_LOW,
            NVDATA_VALUE, SCRATCH_REG_2, SCRATCH_REG_1, SCRATCH_REG_0,
            SERIAL_IF_SHIFT, SERIAL_IF_CONTROL:
                c.rw = ALL_BITS;
            STACK_POINTER_HIGH:   c.rw = 8'h03;
            EXTERNAL_IRQ_MASK:    c.rw = 8'h60;
            EXTERNAL_IRQ_FLAGS:   c.w1c = 8'h60;
            TIMER_IRQ_MASK:       c.rw = 8'h7e;
            TIMER_IRQ_FLAGS:      c.w1c = 8'h7e;
            SELF_PROGRAM_CONTROL: c.rw = 8'h3f;
            RESET_CAUSE:          c.hset = 8'h0f;
            TIMER0_CONTROL_B:     c.rw = 8'hcf;
            TIMER0_CONTROL_A:     c.rw = 8'hf3;
            FAST_CLOCK_CONTROL: begin
                c.rw   = 8'h86;
                c.live = 8'h01;
            end
            CLOCK_DIVIDER:        c.rw = 8'h8f;
            DEAD_TIME_PRESCALE:   c.rw = 8'h03;
            WATCHDOG_CONTROL: begin
                c.rw  = 8'h7f;
                c.w1c = 8'h80;
            end
            POWER_REDUCTION:      c.rw = 8'h0f;
            NVDATA_ADDRESS_HIGH:  c.rw = 8'h01;
            NVDATA_CONTROL:       c.rw = 8'h3f;
            PIN_OUTPUT_VALUE, PIN_DIRECTION, PIN_CHANGE_MASK,
            DIGITAL_INPUT_DISABLE:
                c.rw = 8'h3f;
            PIN_INPUT_VALUE:      c.live = 8'h3f;
            SERIAL_IF_BUFFER:     c.live = ALL_BITS;
            SERIAL_IF_STATUS: begin
                c.rw  = 8'h1f;
                c.w1c = 8'he0;
            end
            default: ;
        endcase
        return c;
    endfunction

endpackage

// *** rtl/io_register_bank.sv ***
// Functional notes
// [R1] software writes zero to reserved bits
// [R2] software never writes reserved addresses
// [R3] bit set/clear only at addresses 0x00-0x1F
// [R4] bit test yields skip on set/clear
// [R5] flagged bits clear on one, keep on zero
// [R6] bit operation touches only the addressed bit
// [R7] reserved reads zero, reserved writes ignored
module io_register_bank
    import io_bank_pkg::*;
(
    input  wire logic              CLK_SYS,
    input  wire logic              RSTN,
    input  wire io_cmd_t           IO_CMD,
    input  wire reg_array_t        HW_FLAG_SET,
    input  wire reg_array_t        HW_STATUS,
    output logic [DATA_W-1:0]      IO_RDATA,
    output logic                   IO_RVALID,
    output logic                   SKIP_NEXT,
    output logic                   TEST_VALID,
    output logic                   OP_IGNORED,
    output reg_array_t             IO_REGS_Q
);

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic              is_bit_op;
    logic              is_test;
    logic              in_bit_range;
    logic              bit_ok;
    logic              wr_en;
    logic [DATA_W-1:0] wr_mask;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] sel_bit;
    logic              addr_mapped;
    bit_class_t        cls;

    assign sel_bit   = ONE_BIT << IO_CMD.bit_sel;
    assign is_bit_op = (IO_CMD.op == OP_SET_BIT)
                     || (IO_CMD.op == OP_CLEAR_BIT);
    assign is_test   = (IO_CMD.op == OP_SKIP_SET)
                     || (IO_CMD.op == OP_SKIP_CLEAR);
    // [R3] bit access range
    assign in_bit_range = (IO_CMD.addr <= BIT_OP_TOP);
    assign bit_ok       = in_bit_range && (is_bit_op || is_test);
    assign cls          = class_of(IO_CMD.addr);
    assign addr_mapped  = |(cls.rw | cls.w1c | cls.hset | cls.live);

    always_comb begin
        wr_en   = 1'b0;
        wr_mask = NO_BITS;
        wr_data = NO_BITS;
        if (IO_CMD.op == OP_WRITE) begin
            wr_en   = 1'b1;
            wr_mask = ALL_BITS;
            wr_data = IO_CMD.wdata;
        end else if (is_bit_op && in_bit_range) begin
            // [R6] single bit only
            wr_en   = 1'b1;
            wr_mask = sel_bit;
            wr_data = (IO_CMD.op == OP_SET_BIT) ? sel_bit : NO_BITS;
        end
    end

    // ------------------------------------------------------------
    // register storage, one entry per address
    // ------------------------------------------------------------
    reg_array_t regs_r;
    reg_array_t regs_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_entry
            localparam logic [ADDR_W-1:0] ADDR = ADDR_W'(gi);
            localparam bit_class_t        C    = class_of(ADDR);
            logic [DATA_W-1:0] m;

            assign m = (wr_en && (IO_CMD.addr == ADDR)) ? wr_mask : NO_BITS;

            always_comb begin
                regs_nxt[gi] = regs_r[gi];
                // plain bits take the written value
                regs_nxt[gi] = (regs_nxt[gi] & ~(m & (C.rw | C.hset)))
                             | (wr_data & m & (C.rw | C.hset));
                // [R5] one clears, zero keeps
                regs_nxt[gi] = regs_nxt[gi] & ~(wr_data & m & C.w1c);
                // hardware set wins over a same-cycle clear
                regs_nxt[gi] = regs_nxt[gi]
                             | (HW_FLAG_SET[gi] & (C.w1c | C.hset));
                regs_nxt[gi] = (regs_nxt[gi] & ~C.live)
                             | (HW_STATUS[gi] & C.live);
                // [R7] reserved bits stay zero
                regs_nxt[gi] = regs_nxt[gi]
                             & (C.rw | C.w1c | C.hset | C.live);
            end

            always_ff @(posedge CLK_SYS or negedge RSTN) begin
                if (!RSTN) begin
                    regs_r[gi] <= REG_RESET;
                end else begin
                    regs_r[gi] <= regs_nxt[gi];
                end
            end
        end
    endgenerate

    assign IO_REGS_Q = regs_r;

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            IO_RDATA  <= NO_BITS;
            IO_RVALID <= 1'b0;
        end else begin
            IO_RVALID <= (IO_CMD.op == OP_READ);
            if (IO_CMD.op == OP_READ) begin
                // [R7] unmapped addresses hold zero
                IO_RDATA <= regs_r[IO_CMD.addr];
            end
        end
    end

    // ------------------------------------------------------------
    // bit test and skip decision
    // ------------------------------------------------------------
    logic tested_bit;

    assign tested_bit = |(regs_r[IO_CMD.addr] & sel_bit);

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            SKIP_NEXT  <= 1'b0;
            TEST_VALID <= 1'b0;
        end else begin
            // [R4] skip on selected bit state
            TEST_VALID <= is_test && in_bit_range;
            SKIP_NEXT  <= is_test && in_bit_range
                       && ((IO_CMD.op == OP_SKIP_SET) ? tested_bit
                                                      : !tested_bit);
        end
    end

    // ------------------------------------------------------------
    // refused operations
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            OP_IGNORED <= 1'b0;
        end else begin
            // [R2] reserved write flagged and dropped
            OP_IGNORED <= ((is_bit_op || is_test) && !bit_ok)
                       || ((IO_CMD.op == OP_WRITE || is_bit_op)
                           && !addr_mapped);
        end
    end

endmodule

// *** verification/io_core_model.sv ***
module io_core_model
    import io_bank_pkg::*;
(
    input  wire logic clk,
    output io_cmd_t   cmd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cmd = '{op: OP_IDLE, default: '0};

    task automatic issue(input io_op_t o, input logic [ADDR_W-1:0] a,
                         input logic [BIT_W-1:0] b,
                         input logic [DATA_W-1:0] d);
        @(negedge clk);
        cmd = '{op: o, addr: a, bit_sel: b, wdata: d};
        @(negedge clk);
        // released fields show inverted values, never the old ones
        cmd = '{op: OP_IDLE, addr: ~a, bit_sel: ~b, wdata: ~d};
    endtask
endmodule

// *** verification/io_register_bank_asserts.sv ***
module io_bank_checker
    import io_bank_pkg::*;
(
    input wire logic              CLK_SYS,
    input wire logic              RSTN,
    input wire io_cmd_t           IO_CMD,
    input wire reg_array_t        HW_FLAG_SET,
    input wire logic [DATA_W-1:0] IO_RDATA,
    input wire logic              IO_RVALID,
    input wire logic              SKIP_NEXT,
    input wire logic              TEST_VALID,
    input wire logic              OP_IGNORED,
    input wire reg_array_t        IO_REGS_Q
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    wire logic              lo  = IO_CMD.addr <= BIT_OP_TOP;
    wire logic              tst = IO_CMD.op inside {OP_SKIP_SET,
                                                   OP_SKIP_CLEAR};
    wire logic              bop = IO_CMD.op inside {OP_SET_BIT, OP_CLEAR_BIT};
    wire logic              quiet = HW_FLAG_SET[IO_CMD.addr] == NO_BITS;
    wire logic [DATA_W-1:0] cur = IO_REGS_Q[IO_CMD.addr];
    wire logic [DATA_W-1:0] msk = ~(ONE_BIT << IO_CMD.bit_sel);
    wire logic              setop = IO_CMD.op == OP_SET_BIT;

    property p_read;
        logic [DATA_W-1:0] d;
        (IO_CMD.op == OP_READ, d = cur) |=> IO_RVALID && IO_RDATA == d;
    endproperty
    a_read: assert property (p_read) else $error("read data wrong");
    property p_test;
        logic v;
        (tst && lo, v = cur[IO_CMD.bit_sel] ^ (IO_CMD.op == OP_SKIP_CLEAR))
            |=> TEST_VALID && SKIP_NEXT == v;
    endproperty
    a_test: assert property (p_test) else $error("skip wrong");
    property p_test_range;
        tst && !lo |=> OP_IGNORED && !TEST_VALID;
    endproperty
    a_test_range: assert property (p_test_range)
        else $error("test high");
    property p_bit_range;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] v;
        (bop && !lo && quiet && IO_CMD.addr != FAST_CLOCK_CONTROL,
            a = IO_CMD.addr, v = cur) |=> OP_IGNORED && IO_REGS_Q[a] == v;
    endproperty
    a_bit_range: assert property (p_bit_range)
        else $error("bit op high");
    property p_others;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] m, v;
        (bop && lo && quiet && IO_CMD.addr != PIN_INPUT_VALUE
            && IO_CMD.addr != SERIAL_IF_BUFFER, a = IO_CMD.addr, m = msk,
            v = cur) |=> (IO_REGS_Q[a] & m) == (v & m);
    endproperty
    a_others: assert property (p_others) else $error("other bits hit");
    property p_scratch;
        logic [DATA_W-1:0] v;
        (bop && IO_CMD.addr == SCRATCH_REG_0,
            v = setop ? cur | ~msk : cur & msk)
            |=> IO_REGS_Q[SCRATCH_REG_0] == v;
    endproperty
    a_scratch: assert property (p_scratch) else $error("bit op wrong");
    property p_w1c;
        logic [DATA_W-1:0] v;
        (IO_CMD.op == OP_WRITE && IO_CMD.addr == SERIAL_IF_STATUS && quiet,
            v = (cur & ~IO_CMD.wdata & 8'he0) | (IO_CMD.wdata & 8'h1f))
            |=> IO_REGS_Q[SERIAL_IF_STATUS] == v;
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag write wrong");
    property p_resv;
        IO_REGS_Q[6'h19] == NO_BITS
            && IO_REGS_Q[PIN_OUTPUT_VALUE][7:6] == 2'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved not zero");

    c_read: cover property (IO_CMD.op == OP_READ ##1 IO_RVALID);
    c_skip: cover property (TEST_VALID && SKIP_NEXT);
    c_ign:  cover property (OP_IGNORED);
endmodule

bind io_register_bank io_bank_checker u_chk (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .IO_CMD(IO_CMD),
    .HW_FLAG_SET(HW_FLAG_SET), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID),
    .SKIP_NEXT(SKIP_NEXT), .TEST_VALID(TEST_VALID),
    .OP_IGNORED(OP_IGNORED), .IO_REGS_Q(IO_REGS_Q)
);

// *** verification/io_register_bank_bit_access_tb.sv ***
module io_register_bank_bit_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import io_bank_pkg::*;
    logic              CLK_SYS, RSTN, IO_RVALID, SKIP_NEXT, TEST_VALID;
    logic              OP_IGNORED;
    logic [DATA_W-1:0] IO_RDATA;
    io_cmd_t           IO_CMD;
    reg_array_t        HW_FLAG_SET, HW_STATUS, IO_REGS_Q;
    int                n_mismatch, total_checks, cycles;

    io_core_model core (.clk(CLK_SYS), .cmd(IO_CMD));
    io_register_bank dut (
        .CLK_SYS(CLK_SYS), .RSTN(RSTN), .IO_CMD(IO_CMD),
        .HW_FLAG_SET(HW_FLAG_SET), .HW_STATUS(HW_STATUS),
        .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID), .SKIP_NEXT(SKIP_NEXT),
        .TEST_VALID(TEST_VALID), .OP_IGNORED(OP_IGNORED),
        .IO_REGS_Q(IO_REGS_Q)
    );

    initial begin
        CLK_SYS = 1'b0;
        forever #4 CLK_SYS = ~CLK_SYS;
    end

    task automatic check(input logic [DATA_W-1:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic op(input io_op_t o, input logic [ADDR_W-1:0] a,
                      input logic [BIT_W-1:0] b, input logic [DATA_W-1:0] d);
        core.issue(o, a, b, d);
    endtask

    task automatic t_reserved();
        check({7'h00, IO_REGS_Q === '0}, 8'h01);
        op(OP_WRITE, PIN_OUTPUT_VALUE, 3'h0, 8'hff);
        op(OP_READ, PIN_OUTPUT_VALUE, 3'h0, 8'h00);
        check({7'h00, IO_RVALID}, 8'h01);
        check(IO_RDATA, 8'h3f);
        op(OP_WRITE, 6'h19, 3'h0, 8'h5a);
        check({7'h00, OP_IGNORED}, 8'h01);
        op(OP_READ, 6'h19, 3'h0, 8'h00);
        check(IO_RDATA, 8'h00);
    endtask

    task automatic t_bits();
        op(OP_WRITE, SCRATCH_REG_0, 3'h0, 8'h81);
        op(OP_SET_BIT, SCRATCH_REG_0, 3'h3, 8'h00);
        check(IO_REGS_Q[SCRATCH_REG_0], 8'h89);
        op(OP_CLEAR_BIT, SCRATCH_REG_0, 3'h7, 8'h00);
        check(IO_REGS_Q[SCRATCH_REG_0], 8'h09);
        op(OP_SET_BIT, NVDATA_ADDRESS_HIGH, 3'h0, 8'h00);
        check(IO_REGS_Q[NVDATA_ADDRESS_HIGH], 8'h01);
        op(OP_SET_BIT, POWER_REDUCTION, 3'h1, 8'h00);
        check({7'h00, OP_IGNORED}, 8'h01);
        check(IO_REGS_Q[POWER_REDUCTION], 8'h00);
    endtask

    task automatic t_flags();
        op(OP_WRITE, SERIAL_IF_STATUS, 3'h0, 8'h15);
        HW_FLAG_SET[SERIAL_IF_STATUS] = 8'hc0;
        @(negedge CLK_SYS);
        HW_FLAG_SET = '0;
        op(OP_SET_BIT, SERIAL_IF_STATUS, 3'h7, 8'h00);
        check(IO_REGS_Q[SERIAL_IF_STATUS], 8'h55);
        op(OP_CLEAR_BIT, SERIAL_IF_STATUS, 3'h0, 8'h00);
        check(IO_REGS_Q[SERIAL_IF_STATUS], 8'h54);
        op(OP_WRITE, SERIAL_IF_STATUS, 3'h0, 8'h00);
        check(IO_REGS_Q[SERIAL_IF_STATUS], 8'h40);
        op(OP_WRITE, SERIAL_IF_STATUS, 3'h0, 8'h40);
        check(IO_REGS_Q[SERIAL_IF_STATUS], 8'h00);
    endtask

    task automatic t_skip();
        op(OP_WRITE, PIN_DIRECTION, 3'h0, 8'h04);
        for (int i = 0; i < 4; i++) begin
            op(i[0] ? OP_SKIP_CLEAR : OP_SKIP_SET, PIN_DIRECTION,
               i[1] ? 3'h3 : 3'h2, 8'h00);
            check({7'h00, TEST_VALID}, 8'h01);
            check({7'h00, SKIP_NEXT}, {7'h00, ~i[1] ^ i[0]});
        end
        op(OP_SKIP_SET, PIN_INPUT_VALUE, 3'h1, 8'h00);
        check({7'h00, SKIP_NEXT}, 8'h01);
        op(OP_SKIP_SET, STATUS_FLAGS, 3'h0, 8'h00);
        check({6'h00, TEST_VALID, OP_IGNORED}, 8'h01);
    endtask

    task automatic t_hw();
        HW_FLAG_SET[RESET_CAUSE] = 8'hf5;
        @(negedge CLK_SYS);
        HW_FLAG_SET = '0;
        check(IO_REGS_Q[RESET_CAUSE], 8'h05);
        op(OP_WRITE, RESET_CAUSE, 3'h0, 8'hf1);
        check(IO_REGS_Q[RESET_CAUSE], 8'h01);
        // clear write and hardware set in the same cycle
        fork
            op(OP_WRITE, TIMER_IRQ_FLAGS, 3'h0, 8'h02);
            begin
                @(negedge CLK_SYS);
                HW_FLAG_SET[TIMER_IRQ_FLAGS] = 8'h02;
                @(negedge CLK_SYS);
                HW_FLAG_SET = '0;
            end
        join
        check(IO_REGS_Q[TIMER_IRQ_FLAGS], 8'h02);
        op(OP_WRITE, TIMER_IRQ_FLAGS, 3'h0, 8'h02);
        check(IO_REGS_Q[TIMER_IRQ_FLAGS], 8'h00);
        op(OP_SKIP_CLEAR, SERIAL_IF_BUFFER, 3'h2, 8'h00);
        check({7'h00, SKIP_NEXT}, 8'h01);
    endtask

    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        HW_FLAG_SET = '0;
        HW_STATUS = '0;
        HW_STATUS[PIN_INPUT_VALUE] = 8'h2a;
        HW_STATUS[SERIAL_IF_BUFFER] = 8'hc3;
        RSTN = 1'b0;
        repeat (2) @(negedge CLK_SYS);
        RSTN = 1'b1;
        t_reserved();
        t_bits();
        t_flags();
        t_skip();
        t_hw();
        wrap_up();
    end
endmodule
